// ==== core/dbdma_engine.sv ====
`timescale 1ns/1ps
module dbdma_engine
  import dbdma_pkg::*;
#(
  parameter int REQ_SOURCES = 15
)
(
  // clock, reset, clock enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // special function register port
  input wire logic [15:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // internal memory bus
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic cpu_stall,
  // hardware request sources, asynchronous to clk
  input wire logic [REQ_SOURCES-1:0] req_src_0,
  input wire logic [REQ_SOURCES-1:0] req_src_1,
  // per-channel underflow interrupt pulses
  output logic [1:0] chan_irq
);

  // the 4-bit source field can name at most 15 sources, value 0 means none
  if (REQ_SOURCES < 1 || REQ_SOURCES > 15) begin : g_bad_sources
    $error("REQ_SOURCES must lie between 1 and 15");
  end

  // pointer step after each byte
  function automatic logic [15:0] step_ptr(input logic [15:0] v, input logic change, input logic dec);
    if (!change) begin
      step_ptr = v;
    end else if (dec) begin
      step_ptr = v - 16'h0001;
    end else begin
      step_ptr = v + 16'h0001;
    end
  endfunction

  // address match helper
  function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
    hit = (a == target);
  endfunction

  logic [7:0] index_status_reg, rdata_reg, temp_reg, mode_one_reg [2], src_snap [2], dst_snap [2], cnt_snap [2];
  logic [3:0] mode_two_reg [2];
  logic [1:0] uf_flag_reg, req_pend_reg, chan_irq_reg, wr_mode_two, sw_trig, reload_now, cap_reset;
  logic [1:0] hw_event, take, uf_event, step_ch, ch_en;
  logic [15:0] mem_addr_reg, src_val [2], dst_val [2], cnt_val [2];
  logic mem_rd_reg, mem_wr_reg, act_ch_reg, sel, complete, burst_more;
  dbdma_state_t state_reg;
  logic [REQ_SOURCES-1:0] s1_reg [2], s2_reg [2], s3_reg [2];
  logic [REQ_SOURCES-1:0] qual_reg [2], qual_next [2], raw_src [2];

  assign sel = index_status_reg[IS_CHANNEL_SELECT_BIT];
  assign raw_src[0] = req_src_0;
  assign raw_src[1] = req_src_1;
  assign complete = (state_reg == DBDMA_WRITE);

  // per-channel decode, write actions and request selection
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      wr_mode_two[c] = sfr_wr && hit(sfr_addr, ADDR_MODE_TWO) && (sel == c[0]);
      sw_trig[c] = wr_mode_two[c] && sfr_wdata[M2_SW_TRIGGER_BIT];
      reload_now[c] = wr_mode_two[c] && sfr_wdata[M2_RELOAD_NOW_BIT];
      cap_reset[c] = wr_mode_two[c] && sfr_wdata[M2_CAPTURE_RESET_BIT];
      ch_en[c] = mode_one_reg[c][M1_ENABLE_BIT];
      hw_event[c] = 1'b0;
      // field value n picks source n-1, zero leaves only the software trigger
      for (int i = 0; i < REQ_SOURCES; i++) begin
        if (mode_two_reg[c] == 4'(i + 1) && qual_next[c][i] && !qual_reg[c][i]) begin
          hw_event[c] = 1'b1;
        end
      end
      step_ch[c] = complete && (act_ch_reg == c[0]);
      uf_event[c] = step_ch[c] && (cnt_val[c] == RESET_WORD);
    end
  end

  // channel 0 first, only enabled channels with a latched request
  always_comb begin
    take = 2'b00;
    if (state_reg == DBDMA_IDLE) begin
      if (req_pend_reg[0] && ch_en[0]) begin
        take = 2'b01;
      end else if (req_pend_reg[1] && ch_en[1]) begin
        take = 2'b10;
      end
    end
  end

  // three-stage synchroniser; a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int c = 0; c < 2; c++) begin
        s1_reg[c] <= '0;
        s2_reg[c] <= '0;
        s3_reg[c] <= '0;
        qual_reg[c] <= '0;
      end
    end else if (ce) begin
      for (int c = 0; c < 2; c++) begin
        s1_reg[c] <= raw_src[c];
        s2_reg[c] <= s1_reg[c];
        s3_reg[c] <= s2_reg[c];
        qual_reg[c] <= qual_next[c];
      end
    end
  end

  // qualified level holds its old value while the stages disagree
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      qual_next[c] = (s2_reg[c] & s3_reg[c]) | (qual_reg[c] & (s2_reg[c] | s3_reg[c]));
    end
  end

  // request latch: many requests during a transfer collapse to one, a new one beats the take
  always_ff @(posedge clk) begin
    if (rst) begin
      req_pend_reg <= 2'b00;
    end else if (ce) begin
      for (int c = 0; c < 2; c++) begin
        if (hw_event[c] || sw_trig[c]) begin
          req_pend_reg[c] <= 1'b1;
        end else if (take[c] || cap_reset[c]) begin
          req_pend_reg[c] <= 1'b0;
        end
      end
    end
  end

  // index/status: select and reload-disable are plain bits
  always_ff @(posedge clk) begin
    if (rst) begin
      index_status_reg <= RESET_BYTE;
    end else if (ce && sfr_wr && hit(sfr_addr, ADDR_INDEX_STATUS)) begin
      index_status_reg <= {sfr_wdata[IS_CHANNEL_SELECT_BIT], sfr_wdata[IS_RELOAD_DIS_BIT], 6'h00};
    end
  end

  // underflow flags: software writes 0 to clear, a same-cycle underflow still sets
  always_ff @(posedge clk) begin
    if (rst) begin
      uf_flag_reg <= 2'b00;
    end else if (ce) begin
      for (int c = 0; c < 2; c++) begin
        if (uf_event[c]) begin
          uf_flag_reg[c] <= 1'b1;
        end else if (sfr_wr && hit(sfr_addr, ADDR_INDEX_STATUS) && !sfr_wdata[c]) begin
          uf_flag_reg[c] <= 1'b0;
        end
      end
    end
  end

  // mode registers; enable drops on underflow when asked to
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int c = 0; c < 2; c++) begin
        mode_one_reg[c] <= RESET_BYTE;
        mode_two_reg[c] <= 4'h0;
      end
    end else if (ce) begin
      for (int c = 0; c < 2; c++) begin
        if (sfr_wr && hit(sfr_addr, ADDR_MODE_ONE) && sel == c[0]) begin
          mode_one_reg[c] <= sfr_wdata;
        end else if (uf_event[c] && mode_one_reg[c][M1_DISABLE_AFTER_BIT]) begin
          mode_one_reg[c][M1_ENABLE_BIT] <= 1'b0;
        end
        if (wr_mode_two[c]) begin
          mode_two_reg[c] <= sfr_wdata[M2_SOURCE_LSB +: M2_SOURCE_WIDTH];
        end
      end
    end
  end

  // interrupt pulse, one per underflow
  always_ff @(posedge clk) begin
    if (rst) begin
      chan_irq_reg <= 2'b00;
    end else if (ce) begin
      chan_irq_reg <= uf_event;
    end
  end

  // source, destination and count for each channel
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic [3:0] ptr_sel_wr;
    logic rl_ptr, rl_cnt, defer;
    assign ptr_sel_wr = {sfr_wr && (sel == c[0]), 3'b000};
    assign defer = mode_one_reg[c][M1_WRITE_DEFER_BIT];
    // underflow reloads pointers unless disabled; count always reloads
    assign rl_ptr = reload_now[c] || (uf_event[c] && !index_status_reg[IS_RELOAD_DIS_BIT]);
    assign rl_cnt = reload_now[c] || uf_event[c];

    dbdma_pointer u_src (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .wr_low(ptr_sel_wr[3] && hit(sfr_addr, ADDR_SOURCE_LOW)),
      .wr_high(ptr_sel_wr[3] && hit(sfr_addr, ADDR_SOURCE_HIGH)),
      .rd_high(sfr_rd && sel == c[0] && hit(sfr_addr, ADDR_SOURCE_HIGH)),
      .wdata(sfr_wdata),
      .defer(defer),
      .reload(rl_ptr),
      .step(step_ch[c]),
      .step_value(step_ptr(src_val[c], mode_one_reg[c][M1_SRC_CHANGE_BIT], mode_one_reg[c][M1_SRC_DEC_BIT])),
      .value(src_val[c]),
      .low_snap(src_snap[c])
    );

    dbdma_pointer u_dst (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .wr_low(ptr_sel_wr[3] && hit(sfr_addr, ADDR_DEST_LOW)),
      .wr_high(ptr_sel_wr[3] && hit(sfr_addr, ADDR_DEST_HIGH)),
      .rd_high(sfr_rd && sel == c[0] && hit(sfr_addr, ADDR_DEST_HIGH)),
      .wdata(sfr_wdata),
      .defer(defer),
      .reload(rl_ptr),
      .step(step_ch[c]),
      .step_value(step_ptr(dst_val[c], mode_one_reg[c][M1_DST_CHANGE_BIT], mode_one_reg[c][M1_DST_DEC_BIT])),
      .value(dst_val[c]),
      .low_snap(dst_snap[c])
    );

    dbdma_pointer u_cnt (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .wr_low(ptr_sel_wr[3] && hit(sfr_addr, ADDR_COUNT_LOW)),
      .wr_high(ptr_sel_wr[3] && hit(sfr_addr, ADDR_COUNT_HIGH)),
      .rd_high(sfr_rd && sel == c[0] && hit(sfr_addr, ADDR_COUNT_HIGH)),
      .wdata(sfr_wdata),
      .defer(defer),
      .reload(rl_cnt),
      .step(step_ch[c]),
      .step_value(cnt_val[c] - 16'h0001),
      .value(cnt_val[c]),
      .low_snap(cnt_snap[c])
    );
  end

  // burst keeps the channel while count has not underflowed and it stays enabled
  assign burst_more = mode_one_reg[act_ch_reg][M1_BURST_BIT] && ch_en[act_ch_reg] && !uf_event[act_ch_reg];

  // transfer sequencer: read cycle, write cycle, then a free cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= DBDMA_IDLE;
      act_ch_reg <= 1'b0;
    end else if (ce) begin
      unique case (state_reg)
        DBDMA_IDLE: begin
          if (take != 2'b00) begin
            state_reg <= DBDMA_READ;
            act_ch_reg <= take[1];
          end
        end
        DBDMA_READ: begin
          state_reg <= DBDMA_WRITE;
        end
        DBDMA_WRITE: begin
          // bursts run back to back; separate requests always leave a gap
          state_reg <= burst_more ? DBDMA_READ : DBDMA_GAP;
        end
        DBDMA_GAP: begin
          state_reg <= DBDMA_IDLE;
        end
      endcase
    end
  end

  // memory bus drive, all from flops
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_addr_reg <= RESET_WORD;
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
    end else if (ce) begin
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      if (state_reg == DBDMA_IDLE && take != 2'b00) begin
        mem_addr_reg <= src_val[take[1]];
        mem_rd_reg <= 1'b1;
      end else if (state_reg == DBDMA_READ) begin
        mem_addr_reg <= dst_val[act_ch_reg];
        mem_wr_reg <= 1'b1;
      end else if (state_reg == DBDMA_WRITE && burst_more) begin
        // pointer updates at this same edge, so use the stepped value directly
        mem_addr_reg <= step_ptr(src_val[act_ch_reg], mode_one_reg[act_ch_reg][M1_SRC_CHANGE_BIT],
          mode_one_reg[act_ch_reg][M1_SRC_DEC_BIT]);
        mem_rd_reg <= 1'b1;
      end
    end
  end

  // temporary holding register between read and write
  always_ff @(posedge clk) begin
    if (rst) begin
      temp_reg <= RESET_BYTE;
    end else if (ce && state_reg == DBDMA_READ) begin
      temp_reg <= mem_rdata;
    end
  end

  // register read data, one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= RESET_BYTE;
    end else if (ce && sfr_rd) begin
      unique case (sfr_addr)
        ADDR_INDEX_STATUS: rdata_reg <= {index_status_reg[7:6], 4'h0, uf_flag_reg};
        ADDR_MODE_ONE: rdata_reg <= mode_one_reg[sel];
        ADDR_MODE_TWO: rdata_reg <= {4'h0, mode_two_reg[sel]};
        ADDR_SOURCE_LOW: rdata_reg <= src_snap[sel];
        ADDR_SOURCE_HIGH: rdata_reg <= src_val[sel][15:8];
        ADDR_DEST_LOW: rdata_reg <= dst_snap[sel];
        ADDR_DEST_HIGH: rdata_reg <= dst_val[sel][15:8];
        ADDR_COUNT_LOW: rdata_reg <= cnt_snap[sel];
        ADDR_COUNT_HIGH: rdata_reg <= cnt_val[sel][15:8];
        default: rdata_reg <= RESET_BYTE;
      endcase
    end
  end

  // outputs; stall covers both cycles of each byte
  assign cpu_stall = (state_reg == DBDMA_READ) || (state_reg == DBDMA_WRITE);
  assign mem_addr = mem_addr_reg;
  assign mem_rd = mem_rd_reg;
  assign mem_wr = mem_wr_reg;
  assign mem_wdata = temp_reg;
  assign sfr_rdata = rdata_reg;
  assign chan_irq = chan_irq_reg;

endmodule

// ==== core/dbdma_pkg.sv ====
package dbdma_pkg;

  // register addresses, shared by both channels
  localparam logic [15:0] ADDR_INDEX_STATUS = 16'h003F;
  localparam logic [15:0] ADDR_MODE_ONE = 16'h0040;
  localparam logic [15:0] ADDR_MODE_TWO = 16'h0041;
  localparam logic [15:0] ADDR_SOURCE_LOW = 16'h0042;
  localparam logic [15:0] ADDR_SOURCE_HIGH = 16'h0043;
  localparam logic [15:0] ADDR_DEST_LOW = 16'h0044;
  localparam logic [15:0] ADDR_DEST_HIGH = 16'h0045;
  localparam logic [15:0] ADDR_COUNT_LOW = 16'h0046;
  localparam logic [15:0] ADDR_COUNT_HIGH = 16'h0047;

  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // index_status_reg fields
  localparam int IS_FLAG0_BIT = 0;
  localparam int IS_FLAG1_BIT = 1;
  localparam int IS_RELOAD_DIS_BIT = 6;
  localparam int IS_CHANNEL_SELECT_BIT = 7;

  // mode_one_reg fields
  localparam int M1_SRC_DEC_BIT = 0;
  localparam int M1_SRC_CHANGE_BIT = 1;
  localparam int M1_DST_DEC_BIT = 2;
  localparam int M1_DST_CHANGE_BIT = 3;
  localparam int M1_BURST_BIT = 4;
  localparam int M1_WRITE_DEFER_BIT = 5;
  localparam int M1_DISABLE_AFTER_BIT = 6;
  localparam int M1_ENABLE_BIT = 7;

  // mode_two_reg fields: low nibble stored, bits 4 to 6 are write-one actions, bit 7 unused
  localparam int M2_SOURCE_LSB = 0;
  localparam int M2_SOURCE_WIDTH = 4;
  localparam int M2_SW_TRIGGER_BIT = 4;
  localparam int M2_RELOAD_NOW_BIT = 5;
  localparam int M2_CAPTURE_RESET_BIT = 6;

  // transfer timing: one read cycle, one write cycle, one free cycle after
  localparam int BYTE_CYCLES = 2;
  localparam int GAP_CYCLES = 1;

  typedef enum logic [1:0] {
    DBDMA_IDLE,
    DBDMA_READ,
    DBDMA_WRITE,
    DBDMA_GAP
  } dbdma_state_t;

endpackage

// ==== core/dbdma_pointer.sv ====
`timescale 1ns/1ps
// one 16-bit channel register with its reload latch and byte-order helpers
module dbdma_pointer
  import dbdma_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register port side
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic rd_high,
  input wire logic [7:0] wdata,
  input wire logic defer,
  // engine side
  input wire logic reload,
  input wire logic step,
  input wire logic [15:0] step_value,
  output logic [15:0] value,
  output logic [7:0] low_snap
);

  logic [7:0] low_hold_reg;
  logic [15:0] latch_reg;
  logic [15:0] latch_next;
  logic [15:0] value_reg;
  logic [7:0] snap_reg;

  // high byte write carries the held low byte along
  assign latch_next = wr_high ? {wdata, low_hold_reg} : latch_reg;

  // low byte waits until the high byte arrives
  always_ff @(posedge clk) begin
    if (rst) begin
      low_hold_reg <= RESET_BYTE;
    end else if (ce && wr_low) begin
      low_hold_reg <= wdata;
    end
  end

  // reload latch
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_reg <= RESET_WORD;
    end else if (ce) begin
      latch_reg <= latch_next;
    end
  end

  // working value: reload or immediate commit beats the engine's step
  always_ff @(posedge clk) begin
    if (rst) begin
      value_reg <= RESET_WORD;
    end else if (ce) begin
      if (reload || (wr_high && !defer)) begin
        value_reg <= latch_next;
      end else if (step) begin
        value_reg <= step_value;
      end
    end
  end

  // low byte frozen at the high byte read, so a moving pointer reads coherently
  always_ff @(posedge clk) begin
    if (rst) begin
      snap_reg <= RESET_BYTE;
    end else if (ce && rd_high) begin
      snap_reg <= value_reg[7:0];
    end
  end

  assign value = value_reg;
  assign low_snap = snap_reg;

endmodule

// ==== test/dbdma_mem_model.sv ====
`timescale 1ns/1ps
// behavioural memory and peripheral space on the far side of the engine
module dbdma_mem_model (
  // clock
  input wire logic clk,
  // memory bus from the engine
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q;

  // known fill so every copied byte can be predicted
  initial begin
    last_q = 8'h00;
    for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
  end

  // data only valid in the read cycle; otherwise inverted so stale bytes never match
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;

  // byte store and last-read tracking
  always @(posedge clk) begin
    if (mem_rd) last_q <= mem[mem_addr];
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end
endmodule

// ==== test/dbdma_props.sv ====
`timescale 1ns/1ps
module dbdma_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [15:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // memory bus
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic cpu_stall,
  input wire logic [1:0] chan_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // two-cycle byte move: read cycle, then write of the held byte
  property p_rd_then_wr; mem_rd |=> mem_wr; endproperty
  a_rd_then_wr: assert property (p_rd_then_wr) else $error("read not followed by write");
  property p_wr_needs_rd; mem_wr |-> $past(mem_rd); endproperty
  a_wr_needs_rd: assert property (p_wr_needs_rd) else $error("write without read");
  property p_temp_byte; mem_wr |-> mem_wdata == $past(mem_rdata); endproperty
  a_temp_byte: assert property (p_temp_byte) else $error("written byte differs");
  property p_stall; cpu_stall == (mem_rd || mem_wr); endproperty
  a_stall: assert property (p_stall) else $error("stall mismatch");
  // underflow pulse follows a write and comes once
  property p_irq_cause; (chan_irq != 2'b00) |-> $past(mem_wr); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without write");
  property p_irq_once; (chan_irq != 2'b00) |=> chan_irq == 2'b00; endproperty
  a_irq_once: assert property (p_irq_once) else $error("irq held");
  // reset state of the outputs, and register port behaviour
  property p_reset_clear;
    $fell(rst) |-> !mem_rd && !mem_wr && sfr_rdata == 8'h00 && mem_addr == 16'h0000 && chan_irq == 2'b00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
  property p_unmapped; sfr_rd && (sfr_addr < 16'h003F || sfr_addr > 16'h0047) |=> sfr_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rdata_hold; !sfr_rd |=> $stable(sfr_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule

bind dbdma_engine dbdma_props u_props (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
  .mem_rdata(mem_rdata), .cpu_stall(cpu_stall), .chan_irq(chan_irq));

// ==== test/tb_dual_channel_byte_dma.sv ====
`timescale 1ns/1ps
module tb_dual_channel_byte_dma;
  import dbdma_pkg::*;
  logic clk, rst, ce, sfr_wr, sfr_rd, mem_rd, mem_wr, cpu_stall;
  logic [15:0] sfr_addr, mem_addr, src, dst, got;
  logic [7:0] sfr_wdata, sfr_rdata, mem_wdata, mem_rdata, m1, ex[4];
  logic [14:0] req_src_0, req_src_1;
  logic [1:0] chan_irq;
  int mismatches, checks_done, cycle, wr_cnt, irq_cnt, n0, r0;
  int seed = 85;
  logic [15:0] rd_q[$];
  int rd_t[$], wr_t[$];

  dbdma_engine dut (.clk(clk), .rst(rst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .cpu_stall(cpu_stall), .req_src_0(req_src_0),
    .req_src_1(req_src_1), .chan_irq(chan_irq));
  dbdma_mem_model mdl (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // bus monitor and hang guard; ceiling well above the fewer than a thousand cycles used
  always @(posedge clk) begin
    cycle++;
    if (mem_rd) begin
      rd_q.push_back(mem_addr);
      rd_t.push_back(cycle);
    end
    if (mem_wr) begin
      wr_cnt++;
      wr_t.push_back(cycle);
    end
    if (chan_irq != 2'b00) irq_cnt++;
    if (cycle == 30000) begin
      mismatches++;
      $display("unexpected at %0t: run did not finish", $time);
      results();
    end
  end

  task automatic check_val(input logic [15:0] g, input logic [15:0] e, input string what);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
    end
  endtask

  // one strobe per call; waiting for a fresh falling edge keeps a low cycle between strobes
  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask

  // low then high on write, high then low on read
  task automatic wr16(input logic [15:0] a, input logic [15:0] v);
    reg_wr(a, v[7:0]);
    reg_wr(a + 16'h0001, v[15:8]);
  endtask

  task automatic rd16(input logic [15:0] a, output logic [15:0] v);
    reg_rd(a + 16'h0001, v[15:8]);
    reg_rd(a, v[7:0]);
  endtask

  task automatic setup(input logic ch, input logic [15:0] s, input logic [15:0] d, input logic [15:0] c,
      input logic [7:0] m);
    reg_wr(ADDR_INDEX_STATUS, {ch, 7'h00});
    wr16(ADDR_SOURCE_LOW, s);
    wr16(ADDR_DEST_LOW, d);
    wr16(ADDR_COUNT_LOW, c);
    reg_wr(ADDR_MODE_ONE, m);
  endtask

  task automatic wait_wr(input int n);
    for (int k = 0; k < 200 && wr_cnt < n; k++) @(negedge clk);
    check_val(16'(wr_cnt), 16'(n), "transfer count");
  endtask

  function automatic logic [15:0] stepped(logic [15:0] p, logic chg, logic dec);
    return !chg ? p : (dec ? p - 16'h0001 : p + 16'h0001);
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    {rst, ce, sfr_wr, sfr_rd} = 4'b1100;
    {sfr_addr, sfr_wdata, req_src_0, req_src_1} = '0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    // reset values of both banks, and an unmapped address
    reg_rd(ADDR_INDEX_STATUS, got[7:0]);
    check_val(got[7:0], 8'h00, "status reset");
    for (int ch = 0; ch < 2; ch++) begin
      reg_wr(ADDR_INDEX_STATUS, {ch[0], 7'h00});
      for (logic [15:0] a = ADDR_MODE_ONE; a <= ADDR_COUNT_HIGH; a++) begin
        reg_rd(a, got[7:0]);
        check_val(got[7:0], 8'h00, "register reset");
      end
    end
    reg_wr(16'h0048, 8'hff);
    reg_rd(16'h0048, got[7:0]);
    check_val(got[7:0], 8'h00, "unmapped");
    // banked registers and byte pairing
    setup(1'b0, 16'h0000, 16'h0000, 16'h1234, 8'h00);
    setup(1'b1, 16'h0000, 16'h0000, 16'habcd, 8'h0a);
    reg_wr(ADDR_INDEX_STATUS, 8'h00);
    reg_wr(ADDR_COUNT_LOW, 8'h77);
    rd16(ADDR_COUNT_LOW, got);
    check_val(got, 16'h1234, "bank 0 count");
    reg_rd(ADDR_MODE_ONE, got[7:0]);
    check_val(got[7:0], 8'h00, "bank 0 mode");
    // software single byte with underflow and reload
    src = 16'($random(seed));
    dst = src ^ 16'h8000;
    ex[0] = mdl.mem[src];
    n0 = wr_cnt;
    setup(1'b0, src, dst, 16'h0000, 8'h8a);
    reg_wr(ADDR_MODE_TWO, 8'h10);
    wait_wr(n0 + 1);
    repeat (3) @(negedge clk);
    check_val(mdl.mem[dst], ex[0], "copied byte");
    check_val(16'(irq_cnt), 16'h0001, "irq pulses");
    reg_rd(ADDR_INDEX_STATUS, got[7:0]);
    check_val(got[7:0], 8'h01, "flag set");
    rd16(ADDR_SOURCE_LOW, got);
    check_val(got, src, "source reloaded");
    reg_wr(ADDR_INDEX_STATUS, 8'h00);
    reg_rd(ADDR_INDEX_STATUS, got[7:0]);
    check_val(got[7:0], 8'h00, "flag cleared");
    // burst of four: source down, destination up, back to back
    src = 16'($random(seed));
    dst = src ^ 16'h8000;
    for (int k = 0; k < 4; k++) ex[k] = mdl.mem[src - 16'(k)];
    n0 = wr_cnt;
    r0 = rd_t.size();
    setup(1'b0, src, dst, 16'h0003, 8'h9b);
    reg_wr(ADDR_MODE_TWO, 8'h10);
    wait_wr(n0 + 4);
    repeat (3) @(negedge clk);
    for (int k = 0; k < 4; k++) check_val(mdl.mem[dst + 16'(k)], ex[k], "burst byte");
    check_val(16'(wr_t[wr_t.size() - 1] - rd_t[r0]), 16'(4 * BYTE_CYCLES - 1), "burst span");
    // random channels and pointer modes
    repeat (6) begin
      m1 = 8'h80 | 8'($random(seed) & 15);
      src = 16'($random(seed));
      dst = src ^ 16'h8000;
      ex[0] = mdl.mem[src];
      n0 = wr_cnt;
      setup(1'($random(seed)), src, dst, 16'h0010, m1);
      reg_wr(ADDR_MODE_TWO, 8'h10);
      wait_wr(n0 + 1);
      repeat (3) @(negedge clk);
      check_val(rd_q[rd_q.size() - 1], src, "read address");
      check_val(mdl.mem[dst], ex[0], "random byte");
      rd16(ADDR_SOURCE_LOW, got);
      check_val(got, stepped(src, m1[1], m1[0]), "source step");
      rd16(ADDR_DEST_LOW, got);
      check_val(got, stepped(dst, m1[3], m1[2]), "dest step");
      rd16(ADDR_COUNT_LOW, got);
      check_val(got, 16'h000f, "count step");
    end
    // every hardware source code, with other lines toggling first
    setup(1'b0, 16'h1000, 16'h9000, 16'h00ff, 8'h8a);
    for (int n = 1; n <= 15; n++) begin
      reg_wr(ADDR_MODE_TWO, 8'(n));
      n0 = wr_cnt;
      @(negedge clk);
      req_src_0 = 15'($random(seed)) & ~(15'h0001 << (n - 1));
      req_src_1 = 15'($random(seed));
      repeat (8) @(negedge clk);
      {req_src_0, req_src_1} = '0;
      repeat (4) @(negedge clk);
      check_val(16'(wr_cnt), 16'(n0), "unselected source");
      req_src_0 = 15'h0001 << (n - 1);
      wait_wr(n0 + 1);
      req_src_0 = '0;
      repeat (4) @(negedge clk);
    end
    // same-edge requests on both channels
    setup(1'b0, 16'h2000, 16'ha000, 16'h00ff, 8'h8a);
    reg_wr(ADDR_MODE_TWO, 8'h01);
    setup(1'b1, 16'h3000, 16'hb000, 16'h00ff, 8'h8a);
    reg_wr(ADDR_MODE_TWO, 8'h01);
    n0 = wr_cnt;
    r0 = rd_q.size();
    @(negedge clk);
    req_src_0 = 15'h0001;
    req_src_1 = 15'h0001;
    wait_wr(n0 + 2);
    check_val(rd_q[r0], 16'h2000, "first served");
    check_val(rd_q[r0 + 1], 16'h3000, "second served");
    check_val(16'(rd_t[r0 + 1] - wr_t[n0] >= GAP_CYCLES + 1), 16'h0001, "free cycle");
    // clock enable low: the trigger write is frozen out, so nothing moves
    @(negedge clk);
    ce = 1'b0;
    n0 = wr_cnt;
    reg_wr(ADDR_MODE_TWO, 8'h10);
    ce = 1'b1;
    repeat (8) @(negedge clk);
    check_val(16'(wr_cnt), 16'(n0), "frozen trigger");
    reg_rd(ADDR_MODE_TWO, got[7:0]);
    check_val(got[7:0], 8'h01, "frozen mode");
    // deferred write waits for reload-now
    reg_wr(ADDR_MODE_ONE, 8'h20);
    wr16(ADDR_SOURCE_LOW, 16'h4321);
    rd16(ADDR_SOURCE_LOW, got);
    check_val(got, 16'h3001, "deferred source");
    reg_wr(ADDR_MODE_TWO, 8'h20);
    rd16(ADDR_SOURCE_LOW, got);
    check_val(got, 16'h4321, "reloaded source");
    results();
  end
endmodule
